//--- src/hbcfg_consts.vh
// Purpose: Constants for the host bridge bus configuration registers
// Assumes: Register index times four gives the AXI4-Lite byte address
// Notes:   Definitions only
`ifndef HBCFG_CONSTS_VH
`define HBCFG_CONSTS_VH

// Register indices
`define HBCFG_IDX_PLACE      8'h1c
`define HBCFG_IDX_RSVD_1D    8'h1d
`define HBCFG_IDX_BURST      8'h1e
`define HBCFG_IDX_RSVD_1F    8'h1f
`define HBCFG_IDX_C2P        8'h20
`define HBCFG_IDX_DSEL       8'h21
`define HBCFG_IDX_P2C        8'h22

// Reset values
`define HBCFG_RST_PLACE      8'h00
`define HBCFG_RST_BURST      8'h00
`define HBCFG_RST_C2P        8'h00
`define HBCFG_RST_DSEL       8'h72
`define HBCFG_RST_P2C        8'h00

// Writable bit masks (reserved bits read zero or fixed)
`define HBCFG_MASK_PLACE     8'h1f
`define HBCFG_MASK_BURST     8'h40
`define HBCFG_MASK_DSEL      8'hbf
`define HBCFG_DSEL_FIXED     8'h40

// Field positions
`define HBCFG_BURST_LINEAR   6
`define HBCFG_C2P_ISA_DYN    0
`define HBCFG_C2P_PCI_DYN    1
`define HBCFG_C2P_POST       2
`define HBCFG_C2P_MERGE      3
`define HBCFG_C2P_BURST      4
`define HBCFG_C2P_FB2B       5
`define HBCFG_DSEL_ADDR2     3
`define HBCFG_DSEL_FASTABT   4
`define HBCFG_DSEL_ROM       5
`define HBCFG_DSEL_FULLIO    7

// Sample point codes
`define HBCFG_SP_SLOW        2'h2
`define HBCFG_SP_SUBTR       2'h3

// VGA hole modes
`define HBCFG_HOLE_A         2'h1
`define HBCFG_HOLE_A_B8      2'h2
`define HBCFG_HOLE_A_B0      2'h3

// Master abort timing in clocks
`define HBCFG_MA_NORMAL_CLKS 3'h5
`define HBCFG_MA_FAST_BASE   3'h2

// AXI responses
`define HBCFG_RESP_OKAY      2'h0
`define HBCFG_RESP_SLVERR    2'h2

`endif

//--- src/hbcfg_regs.v
// Function
// - Bits 0-3 place DRAM banks on 5V bus
// - Bit 4 places L2 SRAM on 5V bus
// - Burst bit 6 enables linear wrapped order
// - Buffer bit 0 enables fast ISA check
// - Buffer bit 1 enables fast PCI check
// - Buffer bit 2 enables CPU-to-PCI posting
// - Buffer bit 3 enables byte merging
// - Buffer bit 4 enables PCI write bursts
// - Buffer bit 5 enables fast back-to-back writes
// - Buffer bits 7:6 select VGA memory hole
// - Select bits 1:0 choose claim sample point
// - As target, code 11 means slow
// - Select bit 3 gives two-clock address phase
// - Select bit 4 picks fast master abort
// - Select bit 5 enables ROM cycle recognition
// - Select bit 7 widens I/O event decode
// - Reset values 72h and 00h
//
// Purpose: Host bridge bus configuration registers behind an AXI4-Lite slave
// Assumes: Decode inputs come from logic on aclk; byte lane 0 carries data
// Notes:   Decode results are registered, one clock after their inputs
//
// The AXI4-Lite interface to the registers was decided locally.
`default_nettype none
`include "hbcfg_consts.vh"

module hbcfg_regs #(
    parameter ADDR_W = 8
) (
    // Clock and reset
    input  wire              aclk,
    input  wire              aresetn,
    // AXI4-Lite write address
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    // AXI4-Lite read address
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // Memory placement
    output reg  [3:0]        bank_on_five_volt_memory_bus,
    output reg               l2_sram_on_five_volt_memory_bus,
    // Burst ordering
    input  wire [1:0]        burst_start_dword,
    output reg               linear_wrap_burst_en,
    output reg  [7:0]        burst_dword_order,
    // CPU-to-PCI buffer controls
    output reg               isa_dyn_check_en,
    output reg               pci_mem_dyn_check_en,
    output reg               cpu_pci_post_en,
    output reg               cpu_pci_merge_en,
    output reg               cpu_pci_burst_en,
    output reg               cpu_pci_fast_b2b_en,
    // CPU address decode
    input  wire [31:0]       cpu_addr,
    output reg               vga_hole_hit,
    output reg               rom_cycle_hit,
    // PCI timing
    output reg  [1:0]        target_claim_sample_master,
    output reg  [1:0]        target_claim_sample_target,
    output reg               addr_phase_two_clk,
    output reg               fast_master_abort_en,
    input  wire              pci_cycle_start,
    input  wire              target_claim_low,
    output reg               master_abort,
    // Power management I/O event decode
    input  wire [15:0]       isa_system_address_lines,
    input  wire [15:0]       pm_event_io_addr,
    output reg               pm_io_event_hit,
    // PCI-to-CPU buffer configuration
    output reg  [7:0]        pci_to_cpu_buffer_cfg
);

    localparam ST_IDLE = 2'b01;
    localparam ST_WAIT = 2'b10;

    // Register storage
    reg [7:0] place_reg;
    reg [7:0] burst_reg;
    reg [7:0] c2p_reg;
    reg [7:0] dsel_reg;
    reg [7:0] p2c_reg;

    // Write channel holding
    reg              aw_full_reg;
    reg              w_full_reg;
    reg [ADDR_W-1:0] aw_addr_reg;
    reg [7:0]        w_data_reg;
    reg              w_lane0_reg;

    // Master abort timer
    reg [1:0] ma_state_reg;
    reg [2:0] ma_count_reg;

    // Byte address of a register index
    function [ADDR_W-1:0] idx_addr;
        input [7:0] idx;
        begin
            idx_addr = {idx[ADDR_W-3:0], 2'b00};
        end
    endfunction

    // Address lies in the register window
    function is_mapped;
        input [ADDR_W-1:0] a;
        begin
            is_mapped = (a >= idx_addr(`HBCFG_IDX_PLACE)) && (a <= idx_addr(`HBCFG_IDX_P2C))
                        && (a[1:0] == 2'b00);
        end
    endfunction

    // Read value of a register
    function [7:0] read_value;
        input [ADDR_W-1:0] a;
        begin
            if (a == idx_addr(`HBCFG_IDX_PLACE))
                read_value = place_reg;
            else if (a == idx_addr(`HBCFG_IDX_BURST))
                read_value = burst_reg;
            else if (a == idx_addr(`HBCFG_IDX_C2P))
                read_value = c2p_reg;
            else if (a == idx_addr(`HBCFG_IDX_DSEL))
                read_value = dsel_reg;
            else if (a == idx_addr(`HBCFG_IDX_P2C))
                read_value = p2c_reg;
            else
                read_value = 8'h00;
        end
    endfunction

    // Target side never uses subtractive sampling
    function [1:0] target_sample;
        input [1:0] code;
        begin
            if (code == `HBCFG_SP_SUBTR)
                target_sample = `HBCFG_SP_SLOW;
            else
                target_sample = code;
        end
    endfunction

    wire       aw_take  = s_axi_awvalid & s_axi_awready;
    wire       w_take   = s_axi_wvalid & s_axi_wready;
    wire       ar_take  = s_axi_arvalid & s_axi_arready;
    wire       aw_have  = aw_full_reg | aw_take;
    wire       w_have   = w_full_reg | w_take;
    wire       do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;
    wire       wr_lane  = w_lane0_reg;
    wire [1:0] eff_code = target_sample(dsel_reg[1:0]);
    wire [2:0] ma_limit = dsel_reg[`HBCFG_DSEL_FASTABT] ?
                          (`HBCFG_MA_FAST_BASE + {1'b0, eff_code}) : `HBCFG_MA_NORMAL_CLKS;

    // Write address and data are taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg   <= 1'b0;
            w_full_reg    <= 1'b0;
            aw_addr_reg   <= {ADDR_W{1'b0}};
            w_data_reg    <= 8'h00;
            w_lane0_reg   <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `HBCFG_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_reg  <= s_axi_wdata[7:0];
                w_lane0_reg <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_full_reg  <= 1'b0;
                w_full_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= is_mapped(aw_addr_reg) ? `HBCFG_RESP_OKAY : `HBCFG_RESP_SLVERR;
            end else begin
                aw_full_reg <= aw_have;
                w_full_reg  <= w_have;
                if (s_axi_bvalid && s_axi_bready)
                    s_axi_bvalid <= 1'b0;
            end
            s_axi_awready <= ~aw_have & ~do_write;
            s_axi_wready  <= ~w_have & ~do_write;
        end
    end

    // Read answers one clock after the address is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `HBCFG_RESP_OKAY;
        end else begin
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h00_0000, read_value(s_axi_araddr)};
                s_axi_rresp   <= is_mapped(s_axi_araddr) ? `HBCFG_RESP_OKAY : `HBCFG_RESP_SLVERR;
            end else if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid  <= 1'b0;
                    s_axi_arready <= 1'b1;
                end
            end else begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Register writes; reserved bits are masked off
    always @(posedge aclk) begin
        if (!aresetn) begin
            place_reg <= `HBCFG_RST_PLACE;
            burst_reg <= `HBCFG_RST_BURST;
            c2p_reg   <= `HBCFG_RST_C2P;
            dsel_reg  <= `HBCFG_RST_DSEL;
            p2c_reg   <= `HBCFG_RST_P2C;
        end else if (do_write && wr_lane) begin
            if (aw_addr_reg == idx_addr(`HBCFG_IDX_PLACE))
                place_reg <= w_data_reg & `HBCFG_MASK_PLACE;
            if (aw_addr_reg == idx_addr(`HBCFG_IDX_BURST))
                burst_reg <= w_data_reg & `HBCFG_MASK_BURST;
            if (aw_addr_reg == idx_addr(`HBCFG_IDX_C2P))
                c2p_reg <= w_data_reg;
            if (aw_addr_reg == idx_addr(`HBCFG_IDX_DSEL))
                dsel_reg <= (w_data_reg & `HBCFG_MASK_DSEL) | `HBCFG_DSEL_FIXED;
            if (aw_addr_reg == idx_addr(`HBCFG_IDX_P2C))
                p2c_reg <= w_data_reg;
        end
    end

    // Register-driven control outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            bank_on_five_volt_memory_bus    <= 4'h0;
            l2_sram_on_five_volt_memory_bus <= 1'b0;
            linear_wrap_burst_en            <= 1'b0;
            isa_dyn_check_en                <= 1'b0;
            pci_mem_dyn_check_en            <= 1'b0;
            cpu_pci_post_en                 <= 1'b0;
            cpu_pci_merge_en                <= 1'b0;
            cpu_pci_burst_en                <= 1'b0;
            cpu_pci_fast_b2b_en             <= 1'b0;
            target_claim_sample_master      <= 2'h0;
            target_claim_sample_target      <= 2'h0;
            addr_phase_two_clk              <= 1'b0;
            fast_master_abort_en            <= 1'b0;
            pci_to_cpu_buffer_cfg           <= 8'h00;
        end else begin
            bank_on_five_volt_memory_bus    <= place_reg[3:0];
            l2_sram_on_five_volt_memory_bus <= place_reg[4];
            linear_wrap_burst_en            <= burst_reg[`HBCFG_BURST_LINEAR];
            isa_dyn_check_en                <= c2p_reg[`HBCFG_C2P_ISA_DYN];
            pci_mem_dyn_check_en            <= c2p_reg[`HBCFG_C2P_PCI_DYN];
            cpu_pci_post_en                 <= c2p_reg[`HBCFG_C2P_POST];
            cpu_pci_merge_en                <= c2p_reg[`HBCFG_C2P_MERGE];
            cpu_pci_burst_en                <= c2p_reg[`HBCFG_C2P_BURST];
            cpu_pci_fast_b2b_en             <= c2p_reg[`HBCFG_C2P_FB2B];
            target_claim_sample_master      <= dsel_reg[1:0];
            target_claim_sample_target      <= eff_code;
            addr_phase_two_clk              <= dsel_reg[`HBCFG_DSEL_ADDR2];
            fast_master_abort_en            <= dsel_reg[`HBCFG_DSEL_FASTABT];
            pci_to_cpu_buffer_cfg           <= p2c_reg;
        end
    end

    // Address decodes and burst order
    always @(posedge aclk) begin
        if (!aresetn) begin
            vga_hole_hit      <= 1'b0;
            rom_cycle_hit     <= 1'b0;
            pm_io_event_hit   <= 1'b0;
            burst_dword_order <= 8'h00;
        end else begin
            case (c2p_reg[7:6])
                `HBCFG_HOLE_A:
                    vga_hole_hit <= (cpu_addr[31:16] == 16'h000a);
                `HBCFG_HOLE_A_B8:
                    vga_hole_hit <= (cpu_addr[31:16] == 16'h000a) || (cpu_addr[31:15] == 17'h00017);
                `HBCFG_HOLE_A_B0:
                    vga_hole_hit <= (cpu_addr[31:16] == 16'h000a) || (cpu_addr[31:16] == 16'h000b);
                default:
                    vga_hole_hit <= 1'b0;
            endcase
            rom_cycle_hit <= dsel_reg[`HBCFG_DSEL_ROM] && cpu_addr[31]
                             && (cpu_addr[26:24] == 3'h7);
            if (dsel_reg[`HBCFG_DSEL_FULLIO])
                pm_io_event_hit <= (isa_system_address_lines == pm_event_io_addr);
            else
                pm_io_event_hit <= (isa_system_address_lines[9:0] == pm_event_io_addr[9:0]);
            // Each slot holds address bits 3:2 of one dword in issue order
            if (burst_reg[`HBCFG_BURST_LINEAR])
                burst_dword_order <= {burst_start_dword + 2'h3, burst_start_dword + 2'h2,
                                      burst_start_dword + 2'h1, burst_start_dword};
            else
                burst_dword_order <= {burst_start_dword ^ 2'h3, burst_start_dword ^ 2'h2,
                                      burst_start_dword ^ 2'h1, burst_start_dword};
        end
    end

    // Unclaimed cycle timer; a claim ends it, and a new start is ignored while it runs
    always @(posedge aclk) begin
        if (!aresetn) begin
            ma_state_reg <= ST_IDLE;
            ma_count_reg <= 3'h0;
            master_abort <= 1'b0;
        end else begin
            master_abort <= 1'b0;
            case (ma_state_reg)
                ST_IDLE: begin
                    if (pci_cycle_start) begin
                        ma_state_reg <= ST_WAIT;
                        ma_count_reg <= 3'h1;
                    end
                end
                ST_WAIT: begin
                    if (!target_claim_low) begin
                        ma_state_reg <= ST_IDLE;
                    end else if (ma_count_reg == ma_limit) begin
                        master_abort <= 1'b1;
                        ma_state_reg <= ST_IDLE;
                    end else begin
                        ma_count_reg <= ma_count_reg + 3'h1;
                    end
                end
                default: begin
                    ma_state_reg <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // hbcfg_regs

`default_nettype wire

//--- verification/hbcfg_regs_asserts.sv
// Purpose: Checker on register bus answers and decode outputs
// Assumes: Decode outputs lag their inputs by one clock
// Notes:   Bound into every instance of the register block
`default_nettype none
module hbcfg_regs_asserts (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus answers
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Decode and timing
    input wire logic [31:0] cpu_addr,
    input wire logic        vga_hole_hit,
    input wire logic        rom_cycle_hit,
    input wire logic [1:0]  burst_start_dword,
    input wire logic [7:0]  burst_dword_order,
    input wire logic [1:0]  target_claim_sample_master,
    input wire logic [1:0]  target_claim_sample_target,
    input wire logic        master_abort
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response changed before accept");
    AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before accept");
    AST_RZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    AST_TGT: assert property (target_claim_sample_target ==
        ((target_claim_sample_master == 2'h3) ? 2'h2 : target_claim_sample_master))
        else $error("target sample point not slow for code 3");
    AST_VGA: assert property ($past(aresetn) &&
        ($past(cpu_addr) < 32'h000a0000 || $past(cpu_addr) > 32'h000bffff) |-> !vga_hole_hit)
        else $error("hole hit outside A0000-BFFFF");
    AST_ROM: assert property ($past(aresetn) && $past(cpu_addr) < 32'h80000000 |-> !rom_cycle_hit)
        else $error("rom hit with address bit 31 low");
    AST_ORDER: assert property ($past(aresetn) |-> burst_dword_order[1:0] == $past(burst_start_dword))
        else $error("burst does not begin at start dword");
    AST_MAPULSE: assert property (master_abort |=> !master_abort)
        else $error("master abort longer than one cycle");
endmodule // hbcfg_regs_asserts

bind hbcfg_regs hbcfg_regs_asserts i_hbcfg_regs_asserts (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .cpu_addr, .vga_hole_hit, .rom_cycle_hit,
    .burst_start_dword, .burst_dword_order, .target_claim_sample_master, .target_claim_sample_target,
    .master_abort);
`default_nettype wire

//--- verification/hbcfg_pci_target.sv
// Purpose: PCI target that claims a cycle after a set delay, or never
// Assumes: Claim line is pulled up when no target drives it
// Notes:   Claim lasts one clock
`default_nettype none
module hbcfg_pci_target (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Bench control
    input  wire logic       claim_en,
    input  wire logic [3:0] claim_dly,
    // PCI side
    input  wire logic       pci_cycle_start,
    output wire logic       target_claim_low
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_reg;
    logic       busy_reg;
    always @(posedge aclk) begin
        if (!aresetn) begin
            busy_reg <= 1'b0;
            cnt_reg  <= 4'h0;
        end else if (pci_cycle_start && !busy_reg) begin
            busy_reg <= claim_en;
            cnt_reg  <= claim_dly;
        end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 4'h1;
            if (cnt_reg == 4'h0) busy_reg <= 1'b0;
        end
    end
    assign target_claim_low = !(busy_reg && cnt_reg == 4'h0);
endmodule // hbcfg_pci_target
`default_nettype wire

//--- verification/hbcfg_regs_tb_top.sv
// Purpose: Self-checking bench for the bus configuration registers
// Assumes: Byte address is register index times four
// Notes:   Abort lengths are compared against normal mode
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end
module hbcfg_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, l2_sram_on_five_volt_memory_bus, claim_en;
    logic linear_wrap_burst_en, isa_dyn_check_en, pci_mem_dyn_check_en, cpu_pci_post_en, cpu_pci_merge_en;
    logic cpu_pci_burst_en, cpu_pci_fast_b2b_en, vga_hole_hit, rom_cycle_hit, addr_phase_two_clk;
    logic fast_master_abort_en, pci_cycle_start, target_claim_low, master_abort, pm_io_event_hit;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, burst_dword_order, pci_to_cpu_buffer_cfg;
    logic [31:0] s_axi_wdata, s_axi_rdata, cpu_addr;
    logic [3:0]  s_axi_wstrb, bank_on_five_volt_memory_bus, claim_dly;
    logic [1:0]  s_axi_bresp, s_axi_rresp, burst_start_dword, target_claim_sample_master, target_claim_sample_target;
    logic [15:0] isa_system_address_lines, pm_event_io_addr;
    int          err_count, checked, cyc, i, k, nn, n;
    logic [7:0]  ra[9] = '{8'h70, 8'h74, 8'h78, 8'h7c, 8'h80, 8'h84, 8'h88, 8'h8c, 8'h71};
    logic [7:0]  rst_v[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h72, 8'h00, 8'h00, 8'h00};
    logic [7:0]  ff_v[9] = '{8'h1f, 8'h00, 8'h40, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00};
    logic [1:0]  rs[9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2};
    logic [31:0] va[4] = '{32'h000a8000, 32'h000b4000, 32'h000bc000, 32'h000c0000};
    logic [3:0]  vexp[4] = '{4'h0, 4'h1, 4'h5, 4'h7};
    logic [7:0]  dv[2] = '{8'hac, 8'h04};
    wire  [5:0]  c2p_out = {cpu_pci_fast_b2b_en, cpu_pci_burst_en, cpu_pci_merge_en, cpu_pci_post_en,
                            pci_mem_dyn_check_en, isa_dyn_check_en};

    hbcfg_regs #(.ADDR_W(8)) i_hbcfg_regs (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .bank_on_five_volt_memory_bus, .l2_sram_on_five_volt_memory_bus, .burst_start_dword, .linear_wrap_burst_en,
        .burst_dword_order, .isa_dyn_check_en, .pci_mem_dyn_check_en, .cpu_pci_post_en, .cpu_pci_merge_en,
        .cpu_pci_burst_en, .cpu_pci_fast_b2b_en, .cpu_addr, .vga_hole_hit, .rom_cycle_hit,
        .target_claim_sample_master, .target_claim_sample_target, .addr_phase_two_clk, .fast_master_abort_en,
        .pci_cycle_start, .target_claim_low, .master_abort, .isa_system_address_lines, .pm_event_io_addr,
        .pm_io_event_hit, .pci_to_cpu_buffer_cfg);
    hbcfg_pci_target i_hbcfg_pci_target (.aclk, .aresetn, .claim_en, .claim_dly, .pci_cycle_start,
        .target_claim_low);

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic finish_test;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            finish_test;
        end
    end

    task automatic settle;
        repeat (3) @(posedge aclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] st, input logic [1:0] er);
        logic aw_left, w_left;
        @(posedge aclk);
        aw_left = 1'b1;
        w_left = 1'b1;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= st;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw_left || w_left) begin
            @(posedge aclk);
            if (aw_left && s_axi_awready === 1'b1) begin
                aw_left = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_left && s_axi_wready === 1'b1) begin
                w_left = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        `CHK("bresp", er, s_axi_bresp)
        s_axi_bready <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        `CHK("rdata", {24'h000000, e}, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
        s_axi_rready <= 1'b0;
    endtask

    task automatic abort_len(output int len);
        @(posedge aclk);
        pci_cycle_start <= 1'b1;
        @(posedge aclk);
        pci_cycle_start <= 1'b0;
        len = 0;
        while (master_abort !== 1'b1 && len < 20) begin
            @(posedge aclk);
            len++;
        end
        settle;
    endtask

    function automatic logic [7:0] bord(input logic [1:0] s, input logic l);
        for (int j = 0; j < 4; j++) bord[2*j +: 2] = l ? s + 2'(j) : s ^ 2'(j);
    endfunction

    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, pci_cycle_start, claim_en} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, cpu_addr, claim_dly, burst_start_dword} = '0;
        {isa_system_address_lines, pm_event_io_addr} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 9; i++) rdchk(ra[i], rst_v[i], rs[i]);
        `CHK("p2c", 8'h00, pci_to_cpu_buffer_cfg)
        for (i = 0; i < 9; i++) wr(ra[i], 8'hff, 4'h1, rs[i]);
        for (i = 0; i < 9; i++) rdchk(ra[i], ff_v[i], rs[i]);
        `CHK("p2c", 8'hff, pci_to_cpu_buffer_cfg)
        wr(8'h70, 8'h00, 4'h0, 2'h0);
        rdchk(8'h70, 8'h1f, 2'h0);
        wr(8'h70, 8'h15, 4'h1, 2'h0);
        settle;
        `CHK("banks", 4'h5, bank_on_five_volt_memory_bus)
        `CHK("l2", 1'b1, l2_sram_on_five_volt_memory_bus)
        for (i = 0; i < 6; i++) begin
            wr(8'h80, 8'h01 << i, 4'h1, 2'h0);
            settle;
            `CHK("c2p", 6'h01 << i, c2p_out)
        end
        for (i = 0; i < 4; i++) begin
            wr(8'h80, 8'(i) << 6, 4'h1, 2'h0);
            for (k = 0; k < 4; k++) begin
                cpu_addr <= va[k];
                settle;
                `CHK("vga", vexp[i][k], vga_hole_hit)
            end
        end
        for (i = 0; i < 2; i++) begin
            wr(8'h78, 8'(i) << 6, 4'h1, 2'h0);
            for (k = 0; k < 4; k++) begin
                burst_start_dword <= 2'(k);
                settle;
                `CHK("order", bord(2'(k), i[0]), burst_dword_order)
                `CHK("linear", i[0], linear_wrap_burst_en)
            end
        end
        cpu_addr <= 32'h87000000;
        isa_system_address_lines <= 16'h1234;
        pm_event_io_addr <= 16'h0234;
        wr(8'h84, 8'h04, 4'h1, 2'h0);
        abort_len(nn);
        `CHK("abortnorm", 6, nn)
        `CHK("normab", 1'b0, fast_master_abort_en)
        for (i = 0; i < 4; i++) begin
            wr(8'h84, 8'h14 | 8'(i), 4'h1, 2'h0);
            settle;
            `CHK("smaster", 2'(i), target_claim_sample_master)
            `CHK("starget", (i == 3) ? 2'h2 : 2'(i), target_claim_sample_target)
            `CHK("fastab", 1'b1, fast_master_abort_en)
            abort_len(n);
            `CHK("abortlen", 3 - ((i == 3) ? 2 : i), nn - n)
        end
        claim_en <= 1'b1;
        claim_dly <= 4'h1;
        abort_len(n);
        `CHK("claimed", 20, n)
        claim_en <= 1'b0;
        for (i = 0; i < 2; i++) begin
            wr(8'h84, dv[i], 4'h1, 2'h0);
            settle;
            `CHK("aphase", dv[i][3], addr_phase_two_clk)
            `CHK("rom", dv[i][5], rom_cycle_hit)
            `CHK("pmio", !dv[i][7], pm_io_event_hit)
            rdchk(8'h84, dv[i] | 8'h40, 2'h0);
        end
        finish_test;
    end
endmodule // hbcfg_regs_tb_top
`default_nettype wire
